// file: common/dbgc_cfg.svh
`ifndef DBGC_CFG_SVH
`define DBGC_CFG_SVH

// ==========================================================
// Special-purpose register numbers
// ==========================================================
`define DBGC_SPR_NUM_W 10
`define DBGC_SPR_MAIN 10'h3F2
`define DBGC_SPR_DCMP 10'h3BD

// ==========================================================
// Main control register fields
// ==========================================================
// Bit 0 of the register is the most significant bit, so a field
// printed at bit n sits at vector index 31-n.
`define DBGC_EXT_DEBUG_BIT 31
`define DBGC_INT_DEBUG_BIT 30
`define DBGC_RST_HI 29
`define DBGC_RST_LO 28
`define DBGC_INSTR_DONE_BIT 27
`define DBGC_BRANCH_BIT 26
`define DBGC_EXCEPT_BIT 25
`define DBGC_TRAP_BIT 24
`define DBGC_MATCH1_BIT 23
`define DBGC_MATCH2_BIT 22
`define DBGC_RNG12_BIT 21
`define DBGC_RNG12_X_BIT 20
`define DBGC_MATCH3_BIT 19
`define DBGC_MATCH4_BIT 18
`define DBGC_RNG34_BIT 17
`define DBGC_RNG34_X_BIT 16
`define DBGC_RNG12_T_BIT 15
`define DBGC_RNG34_T_BIT 14
`define DBGC_FREEZE_BIT 0
`define DBGC_MAIN_WMASK 32'hCFFFC001
`define DBGC_MAIN_RESET 32'h00000000

// ==========================================================
// Data compare control register
// ==========================================================
`define DBGC_DCMP_WMASK 32'hFFCFFF00
`define DBGC_DCMP_RESET 32'h00000000

`endif

// file: common/dbgc_pkg.sv
package dbgc_pkg;

    typedef enum logic [1:0] {
        DBGC_RST_NONE,
        DBGC_RST_PROC,
        DBGC_RST_CHIP,
        DBGC_RST_SYS
    } dbgc_rst_kind_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic priv;
        logic [9:0] num;
        logic [31:0] wdata;
    } dbgc_spr_req_t;

    typedef struct packed {
        logic instr_done;
        logic branch_taken;
        logic exception;
        logic trap;
        logic insn_valid;
        logic [31:0] insn_addr;
    } dbgc_evt_in_t;

    typedef struct packed {
        logic [31:0] cmp_one;
        logic [31:0] cmp_two;
        logic [31:0] cmp_three;
        logic [31:0] cmp_four;
    } dbgc_iac_t;

    typedef struct packed {
        logic [31:0] main_reg;
        logic [31:0] dcmp_reg;
        logic [31:0] rdata;
        logic ack;
        logic fault;
        logic rst_req;
        dbgc_rst_kind_t rst_kind;
        logic [7:0] evt;
        logic any_evt;
        logic irq;
        logic stop;
        logic freeze;
        logic trig;
        logic wait_ok;
    } dbgc_state_t;

endpackage

// file: rtl/dbgc_iac_pair.sv
`timescale 1ns/1ns

module dbgc_iac_pair
    import dbgc_pkg::*;
(
    input wire logic [31:0] addr_i, // Executing instruction address
    input wire logic valid_i, // Address is valid this cycle
    input wire logic [31:0] lo_i, // First comparator value
    input wire logic [31:0] hi_i, // Second comparator value
    input wire logic en_lo_i, // First comparator event enable
    input wire logic en_hi_i, // Second comparator event enable
    input wire logic range_en_i, // Pair forms a range
    input wire logic excl_i, // Range is exclusive
    output logic hit_lo_o, // First comparator event
    output logic hit_hi_o, // Second comparator event
    output logic range_hit_o // Event caused by range compare
);

    logic in_rng;
    logic rng;

    // ==========================================================
    // Range and exact matching
    // ==========================================================
    // The range is lo <= addr < hi; exclusive is its complement.
    always_comb
    begin
        in_rng = (addr_i >= lo_i) && (addr_i < hi_i);
        rng = excl_i ? !in_rng : in_rng;
        if (range_en_i)
        begin
            hit_lo_o = valid_i && en_lo_i && rng;
            hit_hi_o = valid_i && en_hi_i && rng;
        end
        else
        begin
            hit_lo_o = valid_i && en_lo_i && (addr_i == lo_i);
            hit_hi_o = valid_i && en_hi_i && (addr_i == hi_i);
        end
        range_hit_o = range_en_i && (hit_lo_o || hit_hi_o);
    end

endmodule

// file: rtl/dbgc_top.sv
`timescale 1ns/1ns
`include "dbgc_cfg.svh"


module dbgc_top
    import dbgc_pkg::*;
(
    input wire logic clk_i, // Processor clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire dbgc_spr_req_t spr_i, // Register move request
    output logic [31:0] spr_rdata_o, // Read data
    output logic spr_ack_o, // Access accepted pulse
    output logic priv_fault_o, // Unprivileged access pulse
    input wire dbgc_evt_in_t evt_i, // Raw processor events
    input wire dbgc_iac_t iac_i, // Comparator addresses
    input wire logic msr_de_i, // Debug interrupt enable
    input wire logic msr_dwe_i, // Debug-wait enable
    output logic ext_debug_mode_en_o, // External-debug mode
    output logic int_debug_mode_en_o, // Internal-debug mode
    output logic rst_req_o, // Forced reset pulse
    output dbgc_rst_kind_t rst_kind_o, // Kind of forced reset
    output logic [7:0] dbg_evt_o, // Enabled events pulse
    output logic debug_event_o, // Any enabled event
    output logic debug_irq_o, // Debug interrupt request
    output logic debug_stop_o, // Stop request
    output logic freeze_timers_o, // Timer freeze pulse
    output logic trace_trigger_o, // Trace trigger pulse
    output logic debug_wait_ok_o, // Debug-wait available
    output logic [31:0] data_compare_ctrl_o // Second register
);

    dbgc_state_t s_r;
    dbgc_state_t s_nxt;

    logic main_sel;
    logic dcmp_sel;
    logic any_sel;
    logic wr_ok;
    logic rd_ok;
    logic [1:0] rst_fld;
    logic hit1;
    logic hit2;
    logic hit3;
    logic hit4;
    logic rng12_hit;
    logic rng34_hit;
    logic ext_on;
    logic int_on;

    // ==========================================================
    // Register decode
    // ==========================================================
    // Only the two register numbers answer; any other number is
    // left for other units and gets no acknowledge from here.
    assign main_sel = (spr_i.num == `DBGC_SPR_MAIN);
    assign dcmp_sel = (spr_i.num == `DBGC_SPR_DCMP);
    assign any_sel = main_sel || dcmp_sel;
    assign wr_ok = spr_i.wr && spr_i.priv && any_sel;
    assign rd_ok = spr_i.rd && spr_i.priv && any_sel;
    assign rst_fld = spr_i.wdata[`DBGC_RST_HI:`DBGC_RST_LO];

    assign ext_on = s_r.main_reg[`DBGC_EXT_DEBUG_BIT];
    assign int_on = s_r.main_reg[`DBGC_INT_DEBUG_BIT];

    // ==========================================================
    // Instruction address comparators
    // ==========================================================
    dbgc_iac_pair u_pair12 (
        .addr_i(evt_i.insn_addr),
        .valid_i(evt_i.insn_valid),
        .lo_i(iac_i.cmp_one),
        .hi_i(iac_i.cmp_two),
        .en_lo_i(s_r.main_reg[`DBGC_MATCH1_BIT]),
        .en_hi_i(s_r.main_reg[`DBGC_MATCH2_BIT]),
        .range_en_i(s_r.main_reg[`DBGC_RNG12_BIT]),
        .excl_i(s_r.main_reg[`DBGC_RNG12_X_BIT]),
        .hit_lo_o(hit1),
        .hit_hi_o(hit2),
        .range_hit_o(rng12_hit)
    );

    dbgc_iac_pair u_pair34 (
        .addr_i(evt_i.insn_addr),
        .valid_i(evt_i.insn_valid),
        .lo_i(iac_i.cmp_three),
        .hi_i(iac_i.cmp_four),
        .en_lo_i(s_r.main_reg[`DBGC_MATCH3_BIT]),
        .en_hi_i(s_r.main_reg[`DBGC_MATCH4_BIT]),
        .range_en_i(s_r.main_reg[`DBGC_RNG34_BIT]),
        .excl_i(s_r.main_reg[`DBGC_RNG34_X_BIT]),
        .hit_lo_o(hit3),
        .hit_hi_o(hit4),
        .range_hit_o(rng34_hit)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.fault = 1'b0;
        s_nxt.rst_req = 1'b0;
        s_nxt.rst_kind = DBGC_RST_NONE;

        // Unprivileged moves change nothing and raise a fault.
        if ((spr_i.wr || spr_i.rd) && any_sel && !spr_i.priv)
        begin
            s_nxt.fault = 1'b1;
        end

        // Range toggles act first so that a write in the same
        // cycle leaves exactly what software wrote.
        if (rng12_hit && s_r.main_reg[`DBGC_RNG12_T_BIT])
        begin
            s_nxt.main_reg[`DBGC_RNG12_X_BIT] =
                !s_r.main_reg[`DBGC_RNG12_X_BIT];
        end
        if (rng34_hit && s_r.main_reg[`DBGC_RNG34_T_BIT])
        begin
            s_nxt.main_reg[`DBGC_RNG34_X_BIT] =
                !s_r.main_reg[`DBGC_RNG34_X_BIT];
        end

        if (wr_ok)
        begin
            s_nxt.ack = 1'b1;
            if (main_sel)
            begin
                // The reset field is never stored, so it reads 00.
                s_nxt.main_reg = spr_i.wdata & `DBGC_MAIN_WMASK;
                if (rst_fld != 2'h0)
                begin
                    s_nxt.rst_req = 1'b1;
                    s_nxt.rst_kind = dbgc_rst_kind_t'(rst_fld);
                end
            end
            else
            begin
                s_nxt.dcmp_reg = spr_i.wdata & `DBGC_DCMP_WMASK;
            end
        end

        if (rd_ok)
        begin
            s_nxt.ack = 1'b1;
            if (main_sel)
            begin
                s_nxt.rdata = s_r.main_reg;
            end
            else
            begin
                s_nxt.rdata = s_r.dcmp_reg;
            end
        end

        // ======================================================
        // Debug events
        // ======================================================
        s_nxt.evt[7] = evt_i.instr_done &&
            s_r.main_reg[`DBGC_INSTR_DONE_BIT];
        s_nxt.evt[6] = evt_i.branch_taken &&
            s_r.main_reg[`DBGC_BRANCH_BIT];
        s_nxt.evt[5] = evt_i.exception &&
            s_r.main_reg[`DBGC_EXCEPT_BIT];
        s_nxt.evt[4] = evt_i.trap &&
            s_r.main_reg[`DBGC_TRAP_BIT];
        s_nxt.evt[3] = hit1;
        s_nxt.evt[2] = hit2;
        s_nxt.evt[1] = hit3;
        s_nxt.evt[0] = hit4;
        s_nxt.any_evt = |s_nxt.evt;

        // Mode effects follow the control bits of the same cycle in
        // which the event was raised.
        s_nxt.irq = s_nxt.any_evt && int_on && msr_de_i;
        s_nxt.stop = s_nxt.any_evt && ext_on;
        s_nxt.freeze = s_nxt.any_evt &&
            s_r.main_reg[`DBGC_FREEZE_BIT];
        s_nxt.trig = s_nxt.any_evt && !int_on && !ext_on;
        s_nxt.wait_ok = msr_dwe_i && !int_on && !ext_on;
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign spr_rdata_o = s_r.rdata;
    assign spr_ack_o = s_r.ack;
    assign priv_fault_o = s_r.fault;
    assign ext_debug_mode_en_o = ext_on;
    assign int_debug_mode_en_o = int_on;
    assign rst_req_o = s_r.rst_req;
    assign rst_kind_o = s_r.rst_kind;
    assign dbg_evt_o = s_r.evt;
    assign debug_event_o = s_r.any_evt;
    assign debug_irq_o = s_r.irq;
    assign debug_stop_o = s_r.stop;
    assign freeze_timers_o = s_r.freeze;
    assign trace_trigger_o = s_r.trig;
    assign debug_wait_ok_o = s_r.wait_ok;
    assign data_compare_ctrl_o = s_r.dcmp_reg;

endmodule

// file: testbench/dbgc_top_properties.sv
`timescale 1ns/1ns
`include "dbgc_cfg.svh"

// ==========================================================
// Port-level checker for the debug control block
// ==========================================================
module dbgc_top_properties
    import dbgc_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire dbgc_spr_req_t spr_i, // Request
    input wire logic spr_ack_o, // Ack
    input wire logic priv_fault_o, // Fault
    input wire dbgc_evt_in_t evt_i, // Raw events
    input wire logic msr_de_i, // Irq enable
    input wire logic msr_dwe_i, // Wait enable
    input wire logic ext_debug_mode_en_o, // Ext mode
    input wire logic int_debug_mode_en_o, // Int mode
    input wire logic rst_req_o, // Reset pulse
    input wire dbgc_rst_kind_t rst_kind_o, // Reset kind
    input wire logic [7:0] dbg_evt_o, // Events
    input wire logic debug_event_o, // Any event
    input wire logic debug_irq_o, // Irq
    input wire logic freeze_timers_o, // Freeze
    input wire logic trace_trigger_o, // Trigger
    input wire logic debug_wait_ok_o // Wait ok
);
    logic hit;
    logic acc;
    logic wr_main;
    assign hit = spr_i.num == `DBGC_SPR_MAIN || spr_i.num == `DBGC_SPR_DCMP;
    assign acc = (spr_i.rd || spr_i.wr) && spr_i.priv && hit;
    assign wr_main = spr_i.wr && spr_i.priv && spr_i.num == `DBGC_SPR_MAIN;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Guards on the reset cycle keep $past from seeing pre-reset values.
    property p_ack; acc |=> spr_ack_o && !priv_fault_o; endproperty
    a_ack: assert property (p_ack) else $error("access not acknowledged");
    property p_fault; (spr_i.rd || spr_i.wr) && !spr_i.priv && hit |=> priv_fault_o && !spr_ack_o;
    endproperty
    a_fault: assert property (p_fault) else $error("unprivileged access accepted");
    property p_rst; wr_main |=> rst_req_o == ($past(spr_i.wdata[29:28]) != 2'h0)
        && rst_kind_o == $past(spr_i.wdata[29:28]); endproperty
    a_rst: assert property (p_rst) else $error("forced reset wrong");
    property p_mode; wr_main |=> ext_debug_mode_en_o == $past(spr_i.wdata[31])
        && int_debug_mode_en_o == $past(spr_i.wdata[30]); endproperty
    a_mode: assert property (p_mode) else $error("mode bits wrong");
    property p_irq; !$past(rst_i) |-> debug_irq_o == (debug_event_o
        && $past(int_debug_mode_en_o) && $past(msr_de_i)); endproperty
    a_irq: assert property (p_irq) else $error("debug irq wrong");
    property p_trig; !$past(rst_i) |-> trace_trigger_o == (debug_event_o
        && !$past(ext_debug_mode_en_o) && !$past(int_debug_mode_en_o)); endproperty
    a_trig: assert property (p_trig) else $error("trace trigger wrong");
    property p_wait; !$past(rst_i) |-> debug_wait_ok_o == ($past(msr_dwe_i)
        && !$past(ext_debug_mode_en_o) && !$past(int_debug_mode_en_o)); endproperty
    a_wait: assert property (p_wait) else $error("wait availability wrong");
    property p_evt; !$past(rst_i) |-> (dbg_evt_o[7:4] & ~{$past(evt_i.instr_done),
        $past(evt_i.branch_taken), $past(evt_i.exception), $past(evt_i.trap)}) == 4'h0;
    endproperty
    a_evt: assert property (p_evt) else $error("event without cause");
    property p_any; debug_event_o == (dbg_evt_o != 8'h00); endproperty
    a_any: assert property (p_any) else $error("any-event wrong");
    property p_freeze; freeze_timers_o |-> debug_event_o; endproperty
    a_freeze: assert property (p_freeze) else $error("freeze without event");
endmodule

bind dbgc_top dbgc_top_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .spr_i(spr_i),
    .spr_ack_o(spr_ack_o), .priv_fault_o(priv_fault_o), .evt_i(evt_i), .msr_de_i(msr_de_i),
    .msr_dwe_i(msr_dwe_i), .ext_debug_mode_en_o(ext_debug_mode_en_o),
    .int_debug_mode_en_o(int_debug_mode_en_o), .rst_req_o(rst_req_o),
    .rst_kind_o(rst_kind_o), .dbg_evt_o(dbg_evt_o), .debug_event_o(debug_event_o),
    .debug_irq_o(debug_irq_o), .freeze_timers_o(freeze_timers_o),
    .trace_trigger_o(trace_trigger_o), .debug_wait_ok_o(debug_wait_ok_o));

// file: testbench/tb_debug_control_registers.sv
`timescale 1ns/1ns
`include "dbgc_cfg.svh"

module tb_debug_control_registers
    import dbgc_pkg::*;
;
    logic clk, rst, msr_de, msr_dwe, ack, fault, ext, intm, rreq, any, irq, stop, frz, trig, wok;
    dbgc_spr_req_t spr;
    dbgc_evt_in_t evt;
    dbgc_iac_t iac;
    dbgc_rst_kind_t rkind;
    logic [31:0] rdata, dcc;
    logic [7:0] devt;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;

    dbgc_top DUT (.clk_i(clk), .rst_i(rst), .spr_i(spr), .spr_rdata_o(rdata), .spr_ack_o(ack),
        .priv_fault_o(fault), .evt_i(evt), .iac_i(iac), .msr_de_i(msr_de), .msr_dwe_i(msr_dwe),
        .ext_debug_mode_en_o(ext), .int_debug_mode_en_o(intm), .rst_req_o(rreq),
        .rst_kind_o(rkind), .dbg_evt_o(devt), .debug_event_o(any), .debug_irq_o(irq),
        .debug_stop_o(stop), .freeze_timers_o(frz), .trace_trigger_o(trig),
        .debug_wait_ok_o(wok), .data_compare_ctrl_o(dcc));

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [31:0] b(input int n);
        return 32'h80000000 >> n;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Request bits are {rd, wr, priv}; returns just after the taking edge.
    task automatic op(input logic [2:0] rwp, input logic [9:0] n, input logic [31:0] d);
        @(posedge clk);
        spr <= {rwp, n, d};
        @(posedge clk);
        spr <= '0;
        #1;
    endtask

    task automatic rd(input logic [9:0] n, input logic [31:0] exp);
        op(3'h5, n, 32'h00000000);
        check("read ack", ack, 32'h1);
        check("read data", rdata, exp);
    endtask

    task automatic ev(input logic [3:0] raw, input logic [31:0] a, input logic [7:0] exp);
        @(posedge clk);
        evt <= {raw, 1'b1, a};
        @(posedge clk);
        evt <= '0;
        #1;
        check("events", devt, exp);
        check("any event", any, 32'(exp != 8'h00));
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_regs;
        rd(`DBGC_SPR_MAIN, 32'h00000000);
        rd(`DBGC_SPR_DCMP, 32'h00000000);
        check("wait ok", wok, 32'h1);
        op(3'h5, 10'h3F3, 32'h00000000);
        check("unmapped ack", ack, 32'h0);
        op(3'h3, `DBGC_SPR_MAIN, 32'hFFFFFFFF);
        check("mode ext", ext, 32'h1);
        check("mode int", intm, 32'h1);
        rd(`DBGC_SPR_MAIN, 32'hCFFFC001);
        for (int k = 0; k < 4; k++)
        begin
            op(3'h3, `DBGC_SPR_MAIN, 32'(k) << 28);
            check("reset pulse", rreq, 32'(k != 0));
            check("reset kind", rkind, 32'(k));
        end
        op(3'h2, `DBGC_SPR_MAIN, b(0));
        check("fault", fault, 32'h1);
        check("unpriv write", ext, 32'h0);
        op(3'h3, `DBGC_SPR_DCMP, 32'hFFFFFFFF);
        check("second reg out", dcc, 32'hFFCFFF00);
        rd(`DBGC_SPR_DCMP, 32'hFFCFFF00);
        $display("register test done");
    endtask

    task automatic t_events;
        for (int i = 0; i < 4; i++)
        begin
            op(3'h3, `DBGC_SPR_MAIN, b(4 + i) | (i < 3 ? b(31) : 0) | (i < 2 ? b(i) : 0));
            ev(4'h8 >> i, 32'hFFFFFFF0, 8'h80 >> i);
            check("freeze", frz, 32'(i < 3));
            check("stop", stop, 32'(i == 0));
            check("irq", irq, 32'(i == 1));
            check("trigger", trig, 32'(i > 1));
            ev(~(4'h8 >> i), 32'hFFFFFFF0, 8'h00);
        end
        $display("event test done");
    endtask

    task automatic t_compare;
        @(posedge clk);
        iac <= {32'h00001000, 32'h00002000, 32'h00003000, 32'h00004000};
        op(3'h3, `DBGC_SPR_MAIN, b(8) | b(9) | b(12) | b(13));
        for (int j = 0; j < 4; j++)
            ev(4'h0, 32'h00001000 * (j + 1), 8'h08 >> j);
        ev(4'h0, 32'h00001004, 8'h00);
        op(3'h3, `DBGC_SPR_MAIN, b(9) | b(12));
        ev(4'h0, 32'h00001000, 8'h00);
        @(posedge clk);
        iac <= {32'h00000100, 32'h00000200, 32'h00000100, 32'h00000200};
        for (int p = 0; p < 2; p++)
        begin
            op(3'h3, `DBGC_SPR_MAIN, p ? b(12) | b(14) | b(17) : b(8) | b(10) | b(16));
            ev(4'h0, 32'h00000180, p ? 8'h02 : 8'h08);
            rd(`DBGC_SPR_MAIN, p ? b(12) | b(14) | b(17) | b(15)
                : b(8) | b(10) | b(16) | b(11));
            ev(4'h0, 32'h00000180, 8'h00);
            ev(4'h0, 32'h00000300, p ? 8'h02 : 8'h08);
            rd(`DBGC_SPR_MAIN, p ? b(12) | b(14) | b(17) : b(8) | b(10) | b(16));
        end
        $display("compare test done");
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            report_and_stop;
        end
    end

    initial
    begin
        rst = 1'b1;
        spr = '0;
        evt = '0;
        iac = '0;
        msr_de = 1'b1;
        msr_dwe = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_events;
        t_compare;
        report_and_stop;
    end
endmodule
